// ### logic/arp_pkg.sv
package arp_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLOCK_HZ        = 40_000_000;
  localparam int unsigned CONV_MAX_NS     = 4700;
  localparam int unsigned CONV_MAX_CYCLES = CONV_MAX_NS / (1_000_000_000 / CLOCK_HZ);
  localparam int unsigned DO_DELAY_CYCLES = 1;
  localparam logic [7:0]  CONV_CYCLES     = 8'hb4;
  localparam logic [7:0]  CNT_ZERO        = 8'h00;
  localparam int unsigned RESULT_W        = 16;
  localparam int unsigned BYTE_W          = 8;
  localparam int unsigned FIFO_DEPTH      = 4;
  localparam logic [15:0] RESULT_RESET    = 16'h0000;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ACQUIRE = 3'b001,
    ST_CONVERT = 3'b010,
    ST_DONE    = 3'b011,
    ST_READ    = 3'b100
  } arp_state_e;

  typedef struct packed {
    logic       chip_select_n;
    logic       read_convert_sel;
    logic       upper_byte_sel;
  } arp_host_s;

  typedef struct packed {
    logic [7:0] data;
    logic [7:0] oe;
  } arp_bus_s;

endpackage : arp_pkg

// ### logic/arp_readout.sv
`timescale 1ns/1ps
// ****************************************
// small fifo for conversion samples
// ****************************************
module arp_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             i_clock,
  input  wire logic             i_nrst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;
  logic [AW:0]      next_count;

  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;
  assign next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
  assign o_out_valid = (count != '0);

  // ready registered from the next occupancy, so the port leaves a flop;
  // it always equals what the settled count would give this cycle
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) o_in_ready <= 1'b1;
    else         o_in_ready <= (next_count < (AW+1)'(DEPTH));
  end
  assign o_out_data  = mem[rd_ptr];

  // storage write, no reset needed on data
  always_ff @(posedge i_clock) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // pointers and occupancy
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      if (pop)  rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      count <= next_count;
    end
  end
endmodule : arp_fifo

// ****************************************
// parallel result readout
// ****************************************
module arp_readout
  import arp_pkg::*;
(
  input  wire logic                i_clock,
  input  wire logic                i_nrst,
  input  wire arp_pkg::arp_host_s  i_host,
  input  wire logic [15:0]         i_sample,
  input  wire logic                i_sample_valid,
  output logic                     o_sample_ready,
  output arp_pkg::arp_bus_s        o_result_bus,
  output logic                     o_conversion_done_n,
  output logic                     o_reference_on,
  output logic                     o_acquiring
);
  import arp_pkg::*;

  arp_state_e  state;
  arp_state_e  next_state;
  logic        cs_prev;
  logic        cs_fall;
  logic [7:0]  conv_cnt;
  logic [15:0] result;
  logic        shutdown_sel;
  logic [1:0]  do_cnt;
  logic        fifo_valid;
  logic        fifo_take;
  logic [15:0] fifo_data;
  logic [7:0]  conv_age;

  // ****************************************
  // helpers
  // ****************************************
  // hold edge: second select fall seen while acquiring
  function automatic logic hold_edge(input arp_state_e st, input logic fall);
    return (st == ST_ACQUIRE) && fall;
  endfunction : hold_edge

  // byte steering for the output mux
  function automatic logic [7:0] pick_byte(input logic [15:0] word, input logic upper);
    return upper ? word[15:8] : word[7:0];
  endfunction : pick_byte

  // samples from the analog front end queue here; conversion stalls if empty
  arp_fifo #(.WIDTH(RESULT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clock     (i_clock),
    .i_nrst      (i_nrst),
    .i_in_valid  (i_sample_valid),
    .o_in_ready  (o_sample_ready),
    .i_in_data   (i_sample),
    .o_out_valid (fifo_valid),
    .i_out_ready (fifo_take),
    .o_out_data  (fifo_data)
  );

  assign cs_fall   = cs_prev && !i_host.chip_select_n;
  assign fifo_take = (state == ST_CONVERT) && (conv_cnt == CNT_ZERO) && fifo_valid;

  // select edge detector
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) cs_prev <= 1'b1;
    else         cs_prev <= i_host.chip_select_n;
  end

  // sequence of select edges
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:    if (cs_fall && !i_host.read_convert_sel) next_state = ST_ACQUIRE;
      ST_ACQUIRE: if (cs_fall) next_state = ST_CONVERT;
      ST_CONVERT: if (fifo_take) next_state = ST_DONE;
      ST_DONE:    if (cs_fall && i_host.read_convert_sel) next_state = ST_READ;
      ST_READ:    if (i_host.chip_select_n) next_state = ST_IDLE;
      default:    next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) state <= ST_IDLE;
    else         state <= next_state;
  end

  // internal conversion timer, stays inside the 4.7 us budget
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      conv_cnt <= CNT_ZERO;
    end else if (hold_edge(state, cs_fall)) begin
      conv_cnt <= CONV_CYCLES;
    end else if (state == ST_CONVERT && conv_cnt != CNT_ZERO) begin
      conv_cnt <= conv_cnt - 8'h01;
    end
  end

  // cycles spent converting; only the budget check reads it
  // saturates so a long stall on an empty queue cannot wrap back to legal
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) conv_age <= CNT_ZERO;
    else if (state != ST_CONVERT) conv_age <= CNT_ZERO;
    else if (conv_age != 8'hff) conv_age <= conv_age + 8'h01;
  end

  // result latch, untouched until next conversion
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) result <= RESULT_RESET;
    else if (fifo_take) result <= fifo_data;
  end

  // power mode chosen at the hold edge
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      shutdown_sel   <= 1'b0;
      o_reference_on <= 1'b0;
    end else begin
      if (hold_edge(state, cs_fall)) shutdown_sel <= i_host.read_convert_sel;
      if (next_state == ST_ACQUIRE) o_reference_on <= 1'b1;
      else if (fifo_take && shutdown_sel) o_reference_on <= 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) o_acquiring <= 1'b0;
    else         o_acquiring <= (next_state == ST_ACQUIRE);
  end

  // end-of-conversion flag; low from completion through readout
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) o_conversion_done_n <= 1'b1;
    else         o_conversion_done_n <= !(next_state == ST_DONE || next_state == ST_READ);
  end

  // output-valid delay after third fall
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) do_cnt <= 2'h0;
    else if (next_state != ST_READ) do_cnt <= 2'h0;
    else if (do_cnt != 2'(DO_DELAY_CYCLES)) do_cnt <= do_cnt + 2'h1;
  end

  // byte mux and tri-state enables; released outside readout
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_result_bus <= '0;
    end else if (next_state == ST_READ && do_cnt == 2'(DO_DELAY_CYCLES)) begin
      o_result_bus.data <= pick_byte(result, i_host.upper_byte_sel);
      o_result_bus.oe   <= 8'hff;
    end else begin
      o_result_bus.oe   <= 8'h00;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_bus_off;
    @(posedge i_clock) disable iff (!i_nrst)
      (state inside {ST_ACQUIRE, ST_CONVERT}) |=> o_result_bus.oe == 8'h00;
  endproperty
  a_bus_off: assert property (p_bus_off) else $error("bus driven during conversion");

  property p_release;
    @(posedge i_clock) disable iff (!i_nrst)
      (state == ST_READ && i_host.chip_select_n) |=> o_result_bus.oe == 8'h00;
  endproperty
  a_release: assert property (p_release) else $error("bus not released");

  property p_drive;
    @(posedge i_clock) disable iff (!i_nrst)
      (state == ST_DONE && cs_fall && i_host.read_convert_sel) ##1 !i_host.chip_select_n
        |=> o_result_bus.oe == 8'hff;
  endproperty
  a_drive: assert property (p_drive) else $error("bus not driven");

  property p_eoc;
    @(posedge i_clock) disable iff (!i_nrst)
      fifo_take |=> !o_conversion_done_n;
  endproperty
  a_eoc: assert property (p_eoc) else $error("done flag late");

  property p_ignore;
    @(posedge i_clock) disable iff (!i_nrst)
      (state == ST_IDLE && i_host.read_convert_sel) |=> state == ST_IDLE;
  endproperty
  a_ignore: assert property (p_ignore) else $error("start not ignored");

  property p_hold;
    @(posedge i_clock) disable iff (!i_nrst)
      hold_edge(state, cs_fall) |=> state == ST_CONVERT && conv_cnt == CONV_CYCLES;
  endproperty
  a_hold: assert property (p_hold) else $error("no hold on second fall");

  property p_stable;
    @(posedge i_clock) disable iff (!i_nrst)
      !fifo_take |=> $stable(result);
  endproperty
  a_stable: assert property (p_stable) else $error("result changed");

  property p_byte;
    @(posedge i_clock) disable iff (!i_nrst)
      (state == ST_READ && next_state == ST_READ && do_cnt == 2'(DO_DELAY_CYCLES) && !i_host.upper_byte_sel)
        |=> o_result_bus.data == result[7:0];
  endproperty
  a_byte: assert property (p_byte) else $error("wrong byte");

  property p_budget;
    @(posedge i_clock) disable iff (!i_nrst)
      (state == ST_CONVERT) |-> conv_age < 8'(CONV_MAX_CYCLES);
  endproperty
  a_budget: assert property (p_budget) else $error("conversion overrun");

  property p_shutdown;
    @(posedge i_clock) disable iff (!i_nrst)
      (fifo_take && shutdown_sel) |=> !o_reference_on;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("reference stayed on");

  property p_standby;
    @(posedge i_clock) disable iff (!i_nrst)
      (fifo_take && !shutdown_sel) |=> o_reference_on;
  endproperty
  a_standby: assert property (p_standby) else $error("reference dropped in standby");

  property p_start;
    @(posedge i_clock) disable iff (!i_nrst)
      (state == ST_IDLE && cs_fall && !i_host.read_convert_sel) |=> o_acquiring && o_reference_on;
  endproperty
  a_start: assert property (p_start) else $error("acquisition not started");

  property p_idle_flag;
    @(posedge i_clock) disable iff (!i_nrst)
      (state == ST_IDLE) |-> o_conversion_done_n && o_result_bus.oe == 8'h00;
  endproperty
  a_idle_flag: assert property (p_idle_flag) else $error("idle not quiet");

  property p_done_hold;
    @(posedge i_clock) disable iff (!i_nrst)
      (state == ST_READ && !i_host.chip_select_n) |=> !o_conversion_done_n;
  endproperty
  a_done_hold: assert property (p_done_hold) else $error("done flag lost in readout");

  property p_high_byte;
    @(posedge i_clock) disable iff (!i_nrst)
      (state == ST_READ && next_state == ST_READ && do_cnt == 2'(DO_DELAY_CYCLES) && i_host.upper_byte_sel)
        |=> o_result_bus.data == result[15:8];
  endproperty
  a_high_byte: assert property (p_high_byte) else $error("wrong upper byte");
endmodule : arp_readout

// ### testbench/arp_host_model.sv
`timescale 1ns/1ps
// ****************************************
// host bus model on the far side
// ****************************************
module arp_host_model
  import arp_pkg::*;
(
  input  wire logic              i_clock,
  input  wire arp_pkg::arp_bus_s i_result_bus,
  output arp_pkg::arp_host_s     o_host,
  output logic [7:0]             o_bus_line
);
  import arp_pkg::*;
  initial begin
    o_host = 3'b100;
  end
  // released bus follows the clock level, so negedge checks see 8'h55 there, never the stale driven byte
  assign o_bus_line = (i_result_bus.oe === 8'hff) ? i_result_bus.data : {4{i_clock, ~i_clock}};
  // select high for a while, then fall with the read level set
  task automatic select_fall(input logic rc, input int gap);
    @(negedge i_clock);
    o_host.chip_select_n = 1'b1;
    repeat (gap) @(negedge i_clock);
    @(negedge i_clock);
    o_host.chip_select_n    = 1'b0;
    o_host.read_convert_sel = rc;
  endtask : select_fall
  // no input mux here, so no channel switch late in conversion
  task automatic byte_sel(input logic b);
    @(negedge i_clock);
    o_host.upper_byte_sel = b;
  endtask : byte_sel
endmodule : arp_host_model

// ### testbench/adc_result_parallel_readout_tb_top.sv
`timescale 1ns/1ps
module adc_result_parallel_readout_tb_top;
  import arp_pkg::*;
  logic        i_clock        = 1'b0;
  logic        i_nrst         = 1'b0;
  logic [15:0] i_sample       = 16'h0000;
  logic        i_sample_valid = 1'b0;
  arp_host_s   host;
  arp_bus_s    result_bus;
  logic        sample_ready;
  logic        done_n;
  logic        ref_on;
  logic        acquiring;
  logic [7:0]  bus_line;
  int          err_count = 0;
  int          checks    = 0;
  int          q[$];
  int          exp_v;
  int          n;
  int          seed;
  always #12.5 i_clock = ~i_clock;
  arp_readout dut (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_host(host), .i_sample(i_sample),
    .i_sample_valid(i_sample_valid), .o_sample_ready(sample_ready), .o_result_bus(result_bus),
    .o_conversion_done_n(done_n), .o_reference_on(ref_on), .o_acquiring(acquiring)
  );
  arp_host_model host_m (
    .i_clock(i_clock), .i_result_bus(result_bus), .o_host(host), .o_bus_line(bus_line)
  );
  // ****************************************
  // helpers
  // ****************************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask : check
  // bounded wait, sampled between edges to stay clear of races
  task automatic wait_low(input string what, input logic sig_sel, input int bound);
    n = 0;
    while ((sig_sel ? done_n : ~result_bus.oe[0]) !== 1'b0) begin
      @(negedge i_clock);
      n++;
      if (n > bound) begin
        check(what, 16'h0001, 16'h0000);
        tally_and_finish();
      end
    end
  endtask : wait_low
  // valid held until ready seen, taken at the next rising edge
  task automatic push(input logic [15:0] v);
    @(negedge i_clock);
    i_sample       = v;
    i_sample_valid = 1'b1;
    n = 0;
    while (sample_ready !== 1'b1) begin
      @(negedge i_clock);
      n++;
      if (n > 8) begin
        check("ready", 16'h0001, 16'h0000);
        tally_and_finish();
      end
    end
    @(negedge i_clock);
    i_sample_valid = 1'b0;
    q.push_back(v);
  endtask : push
  // one full acquire, convert and two-byte readout
  task automatic readout(input logic rc2);
    host_m.select_fall(1'b0, $urandom_range(3, 0));
    repeat (2) @(negedge i_clock);
    check("acquiring", 16'h1, acquiring);
    check("oe acquire", 16'h0, result_bus.oe);
    host_m.select_fall(rc2, 0);
    wait_low("done", 1'b1, CONV_MAX_CYCLES);
    check("oe convert", 16'h0, result_bus.oe);
    @(negedge i_clock);
    check("reference", {15'h0, ~rc2}, ref_on);
    exp_v = q.pop_front();
    host_m.select_fall(1'b1, 0);
    wait_low("oe", 1'b0, 4);
    check("low byte", exp_v & 16'hff, bus_line);
    host_m.byte_sel(1'b1);
    repeat (2) @(negedge i_clock);
    check("high byte", exp_v >> 8, bus_line);
    host_m.byte_sel(1'b0);
    repeat (2) @(negedge i_clock);
    check("low again", exp_v & 16'hff, bus_line);
    host_m.select_fall(1'b1, 0);
    check("oe release", 16'h0, result_bus.oe);
    check("done idle", 16'h1, done_n);
    repeat (3) @(negedge i_clock);
    check("idle acq", 16'h0, acquiring);
    check("idle oe", 16'h0, result_bus.oe);
  endtask : readout
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = $urandom(32'h8e969e53);
    repeat (2) @(posedge i_clock);
    @(negedge i_clock);
    check("reset oe", 16'h0, result_bus.oe);
    check("reset done", 16'h1, done_n);
    i_nrst = 1'b1;
    $display("test reset done");
    // fill the fifo with both end codes and two random words
    push(16'h0000);
    push(16'hffff);
    push($urandom);
    push($urandom);
    @(negedge i_clock);
    check("fifo full", 16'h0, sample_ready);
    $display("test fill done");
    // alternate standby and shutdown while draining
    for (int m = 0; m < FIFO_DEPTH; m++) begin
      readout(m[0]);
      $display("test readout %0d done", m);
    end
    check("fifo drained", 16'h1, sample_ready);
    tally_and_finish();
  end
endmodule : adc_result_parallel_readout_tb_top
